// *** design/sensor_link_pkg.sv ***
`default_nettype none
package sensor_link_pkg;
  // ==========================================
  // Framing
  localparam int START_BITS = 3;
  localparam int SETUP_BITS = 4;
  localparam int STOP_BITS = 3;
  localparam int FRAME_BITS = START_BITS + SETUP_BITS + STOP_BITS;
  localparam int WORD_BITS = 16;
  localparam int READ_CLOCKS = WORD_BITS + 1;
  localparam int ACK_TAIL_CLOCKS = 2;
  localparam int RESET_BITS = 21;
  localparam int CAL_WORDS = 4;
  // ==========================================
  // Setup codes (values arbitrary, set per part)
  localparam logic [3:0] CODE_PRESSURE = 4'hA;
  localparam logic [3:0] CODE_TEMPERATURE = 4'h9;
  localparam logic [3:0] CODE_CAL1 = 4'h5;
  localparam logic [3:0] CODE_CAL2 = 4'h6;
  localparam logic [3:0] CODE_CAL3 = 4'h3;
  localparam logic [3:0] CODE_CAL4 = 4'hC;
  localparam logic [20:0] RESET_PATTERN = 21'h15_5540;
  // ==========================================
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int SCLK_HALF_NS = 400;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS / CLK_NS) < 1 ? 1 : SCLK_HALF_NS / CLK_NS;
  localparam int MCLK_HZ = 32_768;
  localparam int CONV_MCLKS = 16;

  typedef enum logic [2:0] {
    CMD_PRESSURE,
    CMD_TEMPERATURE,
    CMD_CAL1,
    CMD_CAL2,
    CMD_CAL3,
    CMD_CAL4,
    CMD_RESET
  } cmd_t;
endpackage : sensor_link_pkg
`default_nettype wire

// *** design/sensor_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface sensor_link_if;
  logic sclk;
  logic din;
  logic dout;
  logic mclk;
  modport sensor (input sclk, input din, input mclk, output dout);
  modport host (output sclk, output din, output mclk, input dout);
endinterface : sensor_link_if
`default_nettype wire

// *** design/pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic level_r;
  logic level_nxt;
  always_comb begin
    sh_nxt = {sh_r[1:0], pin};
    level_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : level_r;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sh_r <= 3'h0;
      level_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      level_r <= level_nxt;
    end
  end
  assign level = level_r;
  assign rise = level_nxt & ~level_r;
  assign fall = ~level_nxt & level_r;
endmodule : pin_sync
`default_nettype wire

// *** design/sensor_end.sv ***
// Function
// - Sensor samples data-in, launches data-out on rising clock
// - Host samples and changes on falling clock
// - Host alone generates serial clock
// - Instruction selects result or calibration output
// - Seven instructions: pressure, temperature, four calibrations, reset
// - Three high start, three low stop bits
// - Four-bit setup field selects reading
// - Conversion ack rises during last stop bit
// - Host gives two clocks after ack
// - Clock held low; falling data-out ends conversion
// - Seventeen clocks read sixteen-bit result
// - Readout pauses while clock idles
// - Host reads result before next conversion
// - Reset pattern recognised in any state
// - Reset pattern is twenty-one bits
// - Host ignores data-out during reset pattern
// - Host sends reset before first conversion
// - Host supplies 32.768 kHz master clock
// - Calibration store holds four sixteen-bit words
// - Pressure and temperature results sixteen bits
`timescale 1ns/10ps
`default_nettype none
module sensor_end #(
  parameter logic [15:0] CAL_WORD1 = 16'h1234,
  parameter logic [15:0] CAL_WORD2 = 16'h5678,
  parameter logic [15:0] CAL_WORD3 = 16'h9ABC,
  parameter logic [15:0] CAL_WORD4 = 16'hDEF0,
  parameter int CONV_TICKS = sensor_link_pkg::CONV_MCLKS
) (
  input wire logic ref_clk,
  input wire logic rst,
  sensor_link_if.sensor link,
  input wire logic [15:0] pressure_value,
  input wire logic [15:0] temperature_value,
  output logic busy
);
  import sensor_link_pkg::*;
  if (CONV_TICKS < 1 || CONV_TICKS > 255) begin : g_bad_conv
    $error("CONV_TICKS out of range");
  end

  typedef enum logic [2:0] {
    S_FRAME, S_ACK_TAIL, S_CONVERT, S_READ
  } state_t;

  // ==========================================
  // Pin synchronisers
  logic sclk_rise;
  logic din_lvl;
  logic mclk_rise;
  pin_sync u_sclk (.ref_clk(ref_clk), .rst(rst), .pin(link.sclk), .level(),
                   .rise(sclk_rise), .fall());
  pin_sync u_din (.ref_clk(ref_clk), .rst(rst), .pin(link.din), .level(din_lvl),
                  .rise(), .fall());
  pin_sync u_mclk (.ref_clk(ref_clk), .rst(rst), .pin(link.mclk), .level(),
                   .rise(mclk_rise), .fall());

  // ==========================================
  // Protocol state
  state_t st_r, st_nxt;
  logic [20:0] hist_r, hist_nxt;
  logic [20:0] hist_sh;
  logic [4:0] cnt_r, cnt_nxt;
  logic [7:0] conv_r, conv_nxt;
  logic [16:0] shift_r, shift_nxt;
  logic dout_r, dout_nxt;
  logic conv_pend_r, conv_pend_nxt;
  logic [3:0] setup;
  logic [15:0] word_sel;
  logic is_conv;

  // Shifted history kept apart so setup decode does not loop through the state logic
  assign hist_sh = sclk_rise ? {hist_r[19:0], din_lvl} : hist_r;
  assign setup = hist_sh[STOP_BITS +: SETUP_BITS];

  always_comb begin
    is_conv = 1'b0;
    word_sel = 16'h0000;
    unique case (setup)
      CODE_PRESSURE: begin
        is_conv = 1'b1;
        word_sel = pressure_value;
      end
      CODE_TEMPERATURE: begin
        is_conv = 1'b1;
        word_sel = temperature_value;
      end
      CODE_CAL1: word_sel = CAL_WORD1;
      CODE_CAL2: word_sel = CAL_WORD2;
      CODE_CAL3: word_sel = CAL_WORD3;
      CODE_CAL4: word_sel = CAL_WORD4;
      default: word_sel = 16'h0000;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    hist_nxt = hist_r;
    cnt_nxt = cnt_r;
    conv_nxt = conv_r;
    shift_nxt = shift_r;
    dout_nxt = dout_r;
    conv_pend_nxt = conv_pend_r;
    hist_nxt = hist_sh;
    unique case (st_r)
      S_FRAME: begin
        if (sclk_rise) begin
          cnt_nxt = (cnt_r == 5'(FRAME_BITS)) ? cnt_r : cnt_r + 5'd1;
          // Frame: 111 ssss 000 in the last ten bits
          if (hist_nxt[9:7] == 3'b111 && hist_nxt[2:0] == 3'b000
              && cnt_r >= 5'(FRAME_BITS - 1)) begin
            cnt_nxt = 5'd0;
            if (is_conv) begin
              dout_nxt = 1'b1;
              shift_nxt = {1'b1, word_sel};
              st_nxt = S_ACK_TAIL;
            end else if (setup == CODE_CAL1 || setup == CODE_CAL2 ||
                         setup == CODE_CAL3 || setup == CODE_CAL4) begin
              shift_nxt = {1'b0, word_sel};
              dout_nxt = 1'b0;
              st_nxt = S_READ;
            end
          end
        end
      end
      S_ACK_TAIL: begin
        if (sclk_rise) begin
          cnt_nxt = cnt_r + 5'd1;
          if (cnt_r == 5'(ACK_TAIL_CLOCKS - 1)) begin
            cnt_nxt = 5'd0;
            conv_nxt = 8'(CONV_TICKS);
            st_nxt = S_CONVERT;
          end
        end
      end
      S_CONVERT: begin
        if (mclk_rise) begin
          conv_nxt = conv_r - 8'd1;
          if (conv_r == 8'd1) begin
            dout_nxt = 1'b0;
            shift_nxt = {1'b0, shift_r[15:0]};
            st_nxt = S_READ;
          end
        end
      end
      S_READ: begin
        if (sclk_rise) begin
          cnt_nxt = cnt_r + 5'd1;
          if (cnt_r == 5'd0) begin
            dout_nxt = shift_r[15];
          end else begin
            dout_nxt = shift_r[14];
            shift_nxt = {shift_r[15:0], 1'b0};
          end
          if (cnt_r == 5'(READ_CLOCKS - 1)) begin
            cnt_nxt = 5'd0;
            st_nxt = S_FRAME;
          end
        end
      end
      default: st_nxt = S_FRAME;
    endcase
    if (sclk_rise && st_r == S_READ && cnt_r == 5'(READ_CLOCKS - 1)) begin
      dout_nxt = 1'b0;
    end
    conv_pend_nxt = (st_nxt == S_ACK_TAIL || st_nxt == S_CONVERT);
    if (sclk_rise && hist_nxt == RESET_PATTERN) begin
      st_nxt = S_FRAME;
      cnt_nxt = 5'd0;
      dout_nxt = 1'b0;
      conv_pend_nxt = 1'b0;
      hist_nxt = 21'h00_0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= S_FRAME;
      hist_r <= 21'h00_0000;
      cnt_r <= 5'h00;
      conv_r <= 8'h00;
      shift_r <= 17'h0_0000;
      dout_r <= 1'b0;
      conv_pend_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      hist_r <= hist_nxt;
      cnt_r <= cnt_nxt;
      conv_r <= conv_nxt;
      shift_r <= shift_nxt;
      dout_r <= dout_nxt;
      conv_pend_r <= conv_pend_nxt;
    end
  end

  assign link.dout = dout_r;
  assign busy = conv_pend_r;
endmodule : sensor_end
`default_nettype wire

// *** design/host_end.sv ***
`timescale 1ns/10ps
`default_nettype none
module host_end #(
  parameter int HALF_CYC = sensor_link_pkg::SCLK_HALF_CYC,
  parameter int MCLK_HALF_CYC = 153
) (
  input wire logic ref_clk,
  input wire logic rst,
  sensor_link_if.host link,
  input wire logic req_valid,
  input wire sensor_link_pkg::cmd_t req_cmd,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data
);
  import sensor_link_pkg::*;
  if (HALF_CYC < 1 || HALF_CYC > 255 ||
      MCLK_HALF_CYC < 1 || MCLK_HALF_CYC > 255) begin : g_bad_half
    $error("half period out of range");
  end

  typedef enum logic [2:0] {H_IDLE, H_SEND, H_WAIT, H_READ, H_DONE} hstate_t;

  // ==========================================
  // Clock generation: serial and master
  logic [7:0] div_r, div_nxt;
  logic [7:0] mdiv_r, mdiv_nxt;
  logic mclk_r, mclk_nxt;
  logic tick;
  assign tick = (div_r == 8'(HALF_CYC - 1));

  logic dout_lvl;
  logic dout_fall;
  pin_sync u_dout (.ref_clk(ref_clk), .rst(rst), .pin(link.dout), .level(dout_lvl),
                   .rise(), .fall(dout_fall));

  hstate_t st_r, st_nxt;
  logic sclk_r, sclk_nxt;
  logic din_r, din_nxt;
  logic [20:0] tx_r, tx_nxt;
  logic [4:0] left_r, left_nxt;
  logic [4:0] rd_r, rd_nxt;
  logic [15:0] data_r, data_nxt;
  logic conv_r, conv_nxt;
  logic [3:0] code;

  always_comb begin
    unique case (req_cmd)
      CMD_PRESSURE: code = CODE_PRESSURE;
      CMD_TEMPERATURE: code = CODE_TEMPERATURE;
      CMD_CAL1: code = CODE_CAL1;
      CMD_CAL2: code = CODE_CAL2;
      CMD_CAL3: code = CODE_CAL3;
      CMD_CAL4: code = CODE_CAL4;
      default: code = 4'h0;
    endcase
  end

  always_comb begin
    div_nxt = tick ? 8'h00 : div_r + 8'd1;
    mdiv_nxt = (mdiv_r == 8'(MCLK_HALF_CYC - 1)) ? 8'h00 : mdiv_r + 8'd1;
    mclk_nxt = (mdiv_r == 8'(MCLK_HALF_CYC - 1)) ? ~mclk_r : mclk_r;
    st_nxt = st_r;
    sclk_nxt = sclk_r;
    din_nxt = din_r;
    tx_nxt = tx_r;
    left_nxt = left_r;
    rd_nxt = rd_r;
    data_nxt = data_r;
    conv_nxt = conv_r;
    unique case (st_r)
      H_IDLE: begin
        sclk_nxt = 1'b0;
        if (req_valid) begin
          if (req_cmd == CMD_RESET) begin
            tx_nxt = RESET_PATTERN;
            left_nxt = 5'(RESET_BITS);
          end else begin
            tx_nxt = {11'h000, 3'b111, code, 3'b000};
            tx_nxt = tx_nxt << (RESET_BITS - FRAME_BITS);
            left_nxt = 5'(FRAME_BITS);
          end
          conv_nxt = (req_cmd == CMD_PRESSURE || req_cmd == CMD_TEMPERATURE);
          rd_nxt = (req_cmd == CMD_RESET) ? 5'd0 : 5'(READ_CLOCKS);
          din_nxt = tx_nxt[20];
          st_nxt = H_SEND;
        end
      end
      H_SEND: begin
        if (tick) begin
          sclk_nxt = ~sclk_r;
          if (sclk_r) begin
            tx_nxt = {tx_r[19:0], 1'b0};
            din_nxt = tx_r[19];
            left_nxt = left_r - 5'd1;
            if (left_r == 5'd1) begin
              din_nxt = 1'b0;
              left_nxt = conv_r ? 5'(ACK_TAIL_CLOCKS) : 5'd0;
              // Reset pattern carries no readout
              if (conv_r) begin
                st_nxt = H_WAIT;
              end else if (rd_r == 5'd0) begin
                st_nxt = H_DONE;
              end else begin
                st_nxt = H_READ;
              end
            end
          end
        end
      end
      H_WAIT: begin
        // Two tail clocks, then idle low until data-out falls
        if (left_r != 5'd0) begin
          if (tick) begin
            sclk_nxt = ~sclk_r;
            if (sclk_r) left_nxt = left_r - 5'd1;
          end
        end else if (dout_fall) begin
          st_nxt = H_READ;
        end
      end
      H_READ: begin
        if (tick) begin
          sclk_nxt = ~sclk_r;
          if (sclk_r) begin
            if (rd_r != 5'(READ_CLOCKS)) data_nxt = {data_r[14:0], dout_lvl};
            rd_nxt = rd_r - 5'd1;
            if (rd_r == 5'd1) st_nxt = H_DONE;
          end
        end
      end
      H_DONE: st_nxt = H_IDLE;
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_r <= 8'h00;
      mdiv_r <= 8'h00;
      mclk_r <= 1'b0;
      st_r <= H_IDLE;
      sclk_r <= 1'b0;
      din_r <= 1'b0;
      tx_r <= 21'h00_0000;
      left_r <= 5'h00;
      rd_r <= 5'h00;
      data_r <= 16'h0000;
      conv_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      mdiv_r <= mdiv_nxt;
      mclk_r <= mclk_nxt;
      st_r <= st_nxt;
      sclk_r <= sclk_nxt;
      din_r <= din_nxt;
      tx_r <= tx_nxt;
      left_r <= left_nxt;
      rd_r <= rd_nxt;
      data_r <= data_nxt;
      conv_r <= conv_nxt;
    end
  end

  assign link.sclk = sclk_r;
  assign link.din = din_r;
  assign link.mclk = mclk_r;
  assign req_ready = (st_r == H_IDLE);
  assign rsp_valid = (st_r == H_DONE);
  assign rsp_data = data_r;
endmodule : host_end
`default_nettype wire

// *** testbench/sensor_link_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module sensor_link_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic mclk
);
  import sensor_link_pkg::*;
  // ==========================================
  // Burst tracking
  logic [3:0] quiet_r;
  logic [4:0] burst_r;
  logic [9:0] hist_r;
  logic conv_frame;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      quiet_r <= 4'h0;
      burst_r <= 5'h00;
      hist_r <= 10'h000;
    end else begin
      if ($changed(sclk)) quiet_r <= 4'h0;
      else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
      if ($rose(sclk)) begin
        burst_r <= (quiet_r >= 4'h6) ? 5'h01 : burst_r + 5'h01;
        hist_r <= {hist_r[8:0], din};
      end
    end
  end

  // Start, setup, stop as seen after ten clocks
  assign conv_frame = hist_r[9:7] == 3'h7 && hist_r[2:0] == 3'h0 &&
    (hist_r[6:3] == CODE_PRESSURE || hist_r[6:3] == CODE_TEMPERATURE);

  // ==========================================
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_din_on_fall;
    $changed(din) |-> !sclk;
  endproperty
  a_din_on_fall: assert property (p_din_on_fall)
    else $error("din moved while sclk high");

  property p_sclk_high;
    $rose(sclk) |=> sclk [*3] ##1 !sclk;
  endproperty
  a_sclk_high: assert property (p_sclk_high)
    else $error("sclk high phase wrong length");

  property p_dout_hold;
    $fell(sclk) |=> $stable(dout) [*3];
  endproperty
  a_dout_hold: assert property (p_dout_hold)
    else $error("dout moved after sclk fall");

  property p_dout_rise_high;
    $rose(dout) |-> $past(sclk);
  endproperty
  a_dout_rise_high: assert property (p_dout_rise_high)
    else $error("dout rose outside sclk high");

  property p_mclk;
    $changed(mclk) |=> $stable(mclk) ##1 $changed(mclk);
  endproperty
  a_mclk: assert property (p_mclk)
    else $error("mclk not free running");

  property p_burst;
    quiet_r == 4'h6 |-> burst_r inside {5'd0, 5'd2, 5'd10, 5'd12, 5'd17, 5'd21, 5'd27};
  endproperty
  a_burst: assert property (p_burst)
    else $error("sclk burst of unexpected length");

  property p_kick;
    $fell(dout) && quiet_r >= 4'h6 |-> ##[1:40] $rose(sclk);
  endproperty
  a_kick: assert property (p_kick)
    else $error("no readout after conversion end");

  property p_ack;
    $fell(sclk) && burst_r == 5'h0A && conv_frame |-> dout && !$past(dout, 5);
  endproperty
  a_ack: assert property (p_ack)
    else $error("no ack in last stop bit");

  c_conv: cover property ($fell(sclk) && burst_r == 5'h0A && conv_frame);
  c_read: cover property (quiet_r == 4'h6 && burst_r == 5'd17);
  c_reset: cover property (quiet_r == 4'h6 && burst_r == 5'd21);
  c_cal: cover property (quiet_r == 4'h6 && burst_r == 5'd27);
endmodule : sensor_link_monitor
`default_nettype wire

// *** testbench/tb_pressure_sensor_serial_port.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_pressure_sensor_serial_port;
  import sensor_link_pkg::*;
  localparam logic [15:0] CAL_A = 16'h8421;
  localparam logic [15:0] CAL_B = 16'h0001;
  localparam logic [15:0] CAL_C = 16'hFFFE;
  localparam logic [15:0] CAL_D = 16'h7BDE;
  logic ref_clk, rst, req_valid, req_ready, rsp_valid, busy, busy2;
  cmd_t req_cmd;
  logic [15:0] rsp_data, pressure_value, temperature_value;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  // ==========================================
  // Two ends, plus a spare sensor on a bench-driven link
  sensor_link_if link();
  sensor_link_if link2();
  assign link2.mclk = link.mclk;

  host_end #(.MCLK_HALF_CYC(2)) host_end_inst (.ref_clk(ref_clk), .rst(rst),
    .link(link.host), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  sensor_end #(.CAL_WORD1(CAL_A), .CAL_WORD2(CAL_B), .CAL_WORD3(CAL_C), .CAL_WORD4(CAL_D))
    sensor_end_inst (.ref_clk(ref_clk), .rst(rst), .link(link.sensor),
    .pressure_value(pressure_value), .temperature_value(temperature_value), .busy(busy));
  sensor_end #(.CAL_WORD1(CAL_A), .CAL_WORD2(CAL_B), .CAL_WORD3(CAL_C), .CAL_WORD4(CAL_D))
    sensor_end_inst_b (.ref_clk(ref_clk), .rst(rst), .link(link2.sensor),
    .pressure_value(pressure_value), .temperature_value(temperature_value), .busy(busy2));
  sensor_link_monitor sensor_link_monitor_inst (.ref_clk(ref_clk), .rst(rst),
    .sclk(link.sclk), .din(link.din), .dout(link.dout), .mclk(link.mclk));

  // ==========================================
  // Helpers
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    total_checks++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask : chk

  // Host-side request through the host end
  task automatic xfer(input cmd_t cmd, input logic [15:0] exp);
    logic conv;
    logic seen_busy;
    int n;
    conv = (cmd == CMD_PRESSURE) || (cmd == CMD_TEMPERATURE);
    seen_busy = 1'b0;
    chk("req_ready", 16'h0001, {15'h0000, req_ready});
    req_valid = 1'b1;
    req_cmd = cmd;
    @(negedge ref_clk);
    req_valid = 1'b0;
    for (n = 0; n < 3000 && rsp_valid !== 1'b1; n++) begin
      @(negedge ref_clk);
      seen_busy = seen_busy | (busy === 1'b1);
    end
    chk("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
    if (cmd != CMD_RESET) chk("rsp_data", exp, rsp_data);
    chk("busy_seen", {15'h0000, conv}, {15'h0000, seen_busy});
    chk("busy_end", 16'h0000, {15'h0000, busy});
    repeat (12) @(negedge ref_clk);
  endtask : xfer

  // One serial bit on the spare link, din changed with sclk low
  task automatic bang(input logic b, output logic seen);
    link2.din = b;
    repeat (4) @(negedge ref_clk);
    link2.sclk = 1'b1;
    repeat (4) @(negedge ref_clk);
    seen = link2.dout;
    link2.sclk = 1'b0;
  endtask : bang

  // Abandoned conversion, resync pattern, then paused calibration readout
  task automatic sync_recover;
    logic [9:0] frag;
    logic [9:0] frame;
    logic [15:0] word;
    logic seen;
    int i;
    frag = {3'h7, CODE_PRESSURE, 3'h0};
    frame = {3'h7, CODE_CAL3, 3'h0};
    word = 16'h0000;
    for (i = 9; i >= 0; i--) bang(frag[i], seen);
    chk("abort_ack", 16'h0001, {15'h0000, seen});
    chk("abort_busy", 16'h0001, {15'h0000, busy2});
    for (i = 20; i >= 0; i--) bang(RESET_PATTERN[i], seen);
    for (i = 9; i >= 0; i--) bang(frame[i], seen);
    chk("cal_no_ack", 16'h0000, {15'h0000, seen});
    for (i = 1; i <= 17; i++) begin
      bang(1'b0, seen);
      // Pin read at the end of the high phase: clock 1 already shows bit 15
      if (i <= 16) word = {word[14:0], seen};
      if (i == 9) repeat (300) @(negedge ref_clk);
    end
    chk("resync_word", CAL_C, word);
    chk("resync_busy", 16'h0000, {15'h0000, busy2});
  endtask : sync_recover

  // ==========================================
  // Clock, watchdog, sequence
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      $display("[ERR] watchdog expected done seen hang");
      miscompares++;
      close_out;
    end
  end

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_cmd = CMD_RESET;
    pressure_value = 16'hFFFF;
    temperature_value = 16'h3C5A;
    link2.sclk = 1'b0;
    link2.din = 1'b0;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    xfer(CMD_RESET, 16'h0000);
    xfer(CMD_PRESSURE, 16'hFFFF);
    pressure_value = 16'h8001;
    xfer(CMD_PRESSURE, 16'h8001);
    xfer(CMD_TEMPERATURE, 16'h3C5A);
    xfer(CMD_CAL1, CAL_A);
    xfer(CMD_CAL2, CAL_B);
    xfer(CMD_CAL3, CAL_C);
    xfer(CMD_CAL4, CAL_D);
    sync_recover;
    close_out;
  end
endmodule : tb_pressure_sensor_serial_port
`default_nettype wire
